// file: rtl/sbcs_pkg.sv
// Shared constants, command and bank-state encodings for the two-bank SDRAM command state model.
// Assumes one 100 MHz clock shared by the controller end and the device end.
package sbcs_pkg;

  localparam int NUM_BANKS     = 2;
  localparam int ADDR_W        = 12;
  localparam int BANK_BIT      = 11;
  localparam int AP_BIT        = 10;
  localparam int COL_W         = 8;
  localparam int CNT_W         = 8;
  localparam int CLK_PERIOD_NS = 10;
  localparam int TRP_NS        = 20;
  localparam int ACTIVATE_TO_COLUMN_DELAY_NS       = 20;
  localparam int DATA_IN_TO_PRECHARGE_TIME_NS       = 10;
  localparam int BURST_LEN     = 4;
  localparam int BUS_TURN_CYC  = 1;

  // Least times round up to whole cycles and never fall below one.
  function automatic int min_cycles(input int ns);
    int c;
    c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    return (c < 1) ? 1 : c;
  endfunction : min_cycles

  localparam int TRP_CYC  = min_cycles(TRP_NS);
  localparam int ACTIVATE_TO_COLUMN_DELAY_CYC = min_cycles(ACTIVATE_TO_COLUMN_DELAY_NS);
  localparam int DATA_IN_TO_PRECHARGE_TIME_CYC = min_cycles(DATA_IN_TO_PRECHARGE_TIME_NS);

  // Encoded as {cs_n, ras_n, cas_n, we_n}; deselect stands for any code with cs_n high.
  typedef enum logic [3:0] {
    mode_register_set_cmd = 4'h0,
    refresh_cmd           = 4'h1,
    precharge_cmd         = 4'h2,
    row_activate_cmd      = 4'h3,
    write_cmd             = 4'h4,
    read_cmd              = 4'h5,
    burst_stop_cmd        = 4'h6,
    no_operation_cmd      = 4'h7,
    deselect_cmd          = 4'h8
  } sbcs_cmd_e;

  typedef enum logic [3:0] {
    st_idle         = 4'h0,
    st_activating   = 4'h1,
    st_row_active   = 4'h2,
    st_read         = 4'h3,
    st_read_ap      = 4'h4,
    st_write        = 4'h5,
    st_write_ap     = 4'h6,
    st_write_rec    = 4'h7,
    st_write_rec_ap = 4'h8,
    st_precharging  = 4'h9
  } sbcs_bank_e;

  function automatic sbcs_cmd_e decode(input logic cs_n, input logic ras_n, input logic cas_n, input logic we_n);
    if (cs_n)
    begin
      return deselect_cmd;
    end
    return sbcs_cmd_e'({1'b0, ras_n, cas_n, we_n});
  endfunction : decode

  // Whether a bank-addressed command is permitted in the given bank state.
  function automatic logic cmd_legal(input sbcs_bank_e st, input sbcs_cmd_e c);
    logic quiet;
    quiet = (c == deselect_cmd) || (c == no_operation_cmd);
    unique case (st)
      st_idle:         return quiet || c == burst_stop_cmd || c == row_activate_cmd || c == precharge_cmd;
      st_activating:   return quiet || c == burst_stop_cmd;
      st_row_active,
      st_read,
      st_write:        return quiet || c inside {burst_stop_cmd, read_cmd, write_cmd, precharge_cmd};
      st_read_ap,
      st_write_ap:     return quiet;
      st_write_rec:    return quiet || c inside {burst_stop_cmd, read_cmd, write_cmd};
      st_write_rec_ap: return quiet || c == burst_stop_cmd;
      st_precharging:  return quiet || c == burst_stop_cmd || c == precharge_cmd;
      default:         return 1'b0;
    endcase
  endfunction : cmd_legal

  // Bank-addressed commands reach the bank named by the bank bit; burst stop and
  // precharge-all reach every bank.
  function automatic logic bank_hit(input sbcs_cmd_e c, input logic [ADDR_W-1:0] a, input int b);
    if (c == burst_stop_cmd)
    begin
      return 1'b1;
    end
    if (c == precharge_cmd && a[AP_BIT])
    begin
      return 1'b1;
    end
    return (c inside {read_cmd, write_cmd, row_activate_cmd, precharge_cmd}) && (int'(a[BANK_BIT]) == b);
  endfunction : bank_hit

endpackage : sbcs_pkg

// file: rtl/sbcs_if.sv
// Command pins between an SDRAM controller and the device model.
// Assumes both ends run on the same clock, which is not carried here.
`timescale 1ns/10ps
`default_nettype none
interface sbcs_if;
  logic                           cs_n;
  logic                           ras_n;
  logic                           cas_n;
  logic                           we_n;
  logic [sbcs_pkg::ADDR_W-1:0]    addr;

  modport dev (input cs_n, input ras_n, input cas_n, input we_n, input addr);
  modport ctl (output cs_n, output ras_n, output cas_n, output we_n, output addr);
endinterface : sbcs_if
`default_nettype wire

// file: rtl/sbcs_device.sv
// Device end: per-bank command state machines of a two-bank SDRAM, with illegal-command flagging.
// Assumes command pins are synchronous to clk and come from a controller on the same clock.
`timescale 1ns/10ps
`default_nettype none
module sbcs_device #(
  parameter int BURST_LEN = sbcs_pkg::BURST_LEN
) (
  input  wire logic                          clk,
  input  wire logic                          rst_n,
  sbcs_if.dev                                pins,
  output var  sbcs_pkg::sbcs_bank_e          bank_state [sbcs_pkg::NUM_BANKS],
  output logic                               illegal_cmd,
  output logic                               read_start,
  output logic                               write_start,
  output logic                               start_bank,
  output logic [sbcs_pkg::COL_W-1:0]         start_col
);

  localparam logic [sbcs_pkg::CNT_W-1:0] BL_LOAD   = sbcs_pkg::CNT_W'(BURST_LEN - 1);
  localparam logic [sbcs_pkg::CNT_W-1:0] RP_LOAD   = sbcs_pkg::CNT_W'(sbcs_pkg::TRP_CYC - 1);
  localparam logic [sbcs_pkg::CNT_W-1:0] RCD_LOAD  = sbcs_pkg::CNT_W'(sbcs_pkg::ACTIVATE_TO_COLUMN_DELAY_CYC - 1);
  localparam logic [sbcs_pkg::CNT_W-1:0] DPL_LOAD  = sbcs_pkg::CNT_W'(sbcs_pkg::DATA_IN_TO_PRECHARGE_TIME_CYC - 1);
  localparam logic [sbcs_pkg::CNT_W-1:0] CNT_ZERO  = '0;

  sbcs_pkg::sbcs_cmd_e                 cmd;
  logic                                ap;
  logic [sbcs_pkg::NUM_BANKS-1:0]      bad;
  logic [sbcs_pkg::NUM_BANKS-1:0]      idle;
  logic                                illegal_reg;
  logic                                illegal_next;
  logic                                read_reg;
  logic                                read_next;
  logic                                write_reg;
  logic                                write_next;
  logic                                bank_reg;
  logic                                bank_next;
  logic [sbcs_pkg::COL_W-1:0]          col_reg;
  logic [sbcs_pkg::COL_W-1:0]          col_next;

  // The pins are only looked at through the clocked state below.
  assign cmd = sbcs_pkg::decode(pins.cs_n, pins.ras_n, pins.cas_n, pins.we_n);
  assign ap  = pins.addr[sbcs_pkg::AP_BIT];

  for (genvar b = 0; b < sbcs_pkg::NUM_BANKS; b++)
  begin : g_bank
    sbcs_pkg::sbcs_bank_e          st_reg;
    sbcs_pkg::sbcs_bank_e          st_next;
    logic [sbcs_pkg::CNT_W-1:0]    cnt_reg;
    logic [sbcs_pkg::CNT_W-1:0]    cnt_next;
    logic                          hit;
    logic                          done;
    sbcs_pkg::sbcs_cmd_e           go;

    always_comb
    begin
      hit      = sbcs_pkg::bank_hit(cmd, pins.addr, b);
      bad[b]   = hit && !sbcs_pkg::cmd_legal(st_reg, cmd);
      go       = (hit && !bad[b]) ? cmd : sbcs_pkg::no_operation_cmd;
      done     = (cnt_reg == CNT_ZERO);
      st_next  = st_reg;
      cnt_next = done ? cnt_reg : cnt_reg - 1'b1;
      // An illegal command leaves the bank where it was; its outcome is not modelled.
      unique case (st_reg)
        sbcs_pkg::st_idle:
        begin
          if (go == sbcs_pkg::row_activate_cmd)
          begin
            st_next  = sbcs_pkg::st_activating;
            cnt_next = RCD_LOAD;
          end
        end
        sbcs_pkg::st_activating:
        begin
          if (done)
          begin
            st_next = sbcs_pkg::st_row_active;
          end
        end
        sbcs_pkg::st_row_active,
        sbcs_pkg::st_read,
        sbcs_pkg::st_write,
        sbcs_pkg::st_write_rec:
        begin
          if (go == sbcs_pkg::read_cmd)
          begin
            // A read into a write burst or recovery ends the write and starts the read.
            st_next  = ap ? sbcs_pkg::st_read_ap : sbcs_pkg::st_read;
            cnt_next = BL_LOAD;
          end
          else if (go == sbcs_pkg::write_cmd)
          begin
            st_next  = ap ? sbcs_pkg::st_write_ap : sbcs_pkg::st_write;
            cnt_next = BL_LOAD;
          end
          else if (go == sbcs_pkg::precharge_cmd)
          begin
            st_next  = sbcs_pkg::st_precharging;
            cnt_next = RP_LOAD;
          end
          else if (go == sbcs_pkg::burst_stop_cmd && st_reg != sbcs_pkg::st_write_rec)
          begin
            st_next = sbcs_pkg::st_row_active;
          end
          else if (done && st_reg == sbcs_pkg::st_read)
          begin
            st_next = sbcs_pkg::st_row_active;
          end
          else if (done && st_reg == sbcs_pkg::st_write)
          begin
            st_next  = sbcs_pkg::st_write_rec;
            cnt_next = DPL_LOAD;
          end
          else if (done && st_reg == sbcs_pkg::st_write_rec)
          begin
            st_next = sbcs_pkg::st_row_active;
          end
        end
        sbcs_pkg::st_read_ap:
        begin
          if (done)
          begin
            st_next  = sbcs_pkg::st_precharging;
            cnt_next = RP_LOAD;
          end
        end
        sbcs_pkg::st_write_ap:
        begin
          if (done)
          begin
            st_next  = sbcs_pkg::st_write_rec_ap;
            cnt_next = DPL_LOAD;
          end
        end
        sbcs_pkg::st_write_rec_ap:
        begin
          if (done)
          begin
            st_next  = sbcs_pkg::st_precharging;
            cnt_next = RP_LOAD;
          end
        end
        sbcs_pkg::st_precharging:
        begin
          if (done)
          begin
            st_next = sbcs_pkg::st_idle;
          end
        end
        default:
        begin
          st_next  = sbcs_pkg::st_idle;
          cnt_next = CNT_ZERO;
        end
      endcase
    end

    always_ff @(posedge clk)
    begin
      if (!rst_n)
      begin
        st_reg  <= sbcs_pkg::st_idle;
        cnt_reg <= CNT_ZERO;
      end
      else
      begin
        st_reg  <= st_next;
        cnt_reg <= cnt_next;
      end
    end

    assign idle[b]       = (st_reg == sbcs_pkg::st_idle);
    assign bank_state[b] = st_reg;
  end

  always_comb
  begin
    // Refresh and mode-set need every bank idle, so they are illegal during any burst.
    illegal_next = (|bad) ||
                   ((cmd == sbcs_pkg::refresh_cmd || cmd == sbcs_pkg::mode_register_set_cmd) && !(&idle));
    read_next    = (cmd == sbcs_pkg::read_cmd) && !(|bad);
    write_next   = (cmd == sbcs_pkg::write_cmd) && !(|bad);
    bank_next    = bank_reg;
    col_next     = col_reg;
    if (read_next || write_next)
    begin
      bank_next = pins.addr[sbcs_pkg::BANK_BIT];
      col_next  = pins.addr[sbcs_pkg::COL_W-1:0];
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      illegal_reg <= 1'b0;
      read_reg    <= 1'b0;
      write_reg   <= 1'b0;
      bank_reg    <= 1'b0;
      col_reg     <= '0;
    end
    else
    begin
      illegal_reg <= illegal_next;
      read_reg    <= read_next;
      write_reg   <= write_next;
      bank_reg    <= bank_next;
      col_reg     <= col_next;
    end
  end

  assign illegal_cmd = illegal_reg;
  assign read_start  = read_reg;
  assign write_start = write_reg;
  assign start_bank  = bank_reg;
  assign start_col   = col_reg;

endmodule : sbcs_device
`default_nettype wire

// file: rtl/sbcs_controller.sv
// Controller end: takes one request at a time and drives the SDRAM command pins,
// refusing any request that the shadow state of the addressed bank forbids.
// Assumes the device samples the pins on the same clock edge that follows each command.
`timescale 1ns/10ps
`default_nettype none
module sbcs_controller #(
  parameter int BURST_LEN = sbcs_pkg::BURST_LEN
) (
  input  wire logic                          clk,
  input  wire logic                          rst_n,
  input  wire logic                          req_valid,
  output logic                               req_ready,
  input  wire sbcs_pkg::sbcs_cmd_e           req_op,
  input  wire logic [sbcs_pkg::ADDR_W-1:0]   req_addr,
  sbcs_if.ctl                                pins
);

  localparam logic [sbcs_pkg::CNT_W-1:0] BL_LOAD   = sbcs_pkg::CNT_W'(BURST_LEN - 1);
  localparam logic [sbcs_pkg::CNT_W-1:0] RP_LOAD   = sbcs_pkg::CNT_W'(sbcs_pkg::TRP_CYC - 1);
  localparam logic [sbcs_pkg::CNT_W-1:0] RCD_LOAD  = sbcs_pkg::CNT_W'(sbcs_pkg::ACTIVATE_TO_COLUMN_DELAY_CYC - 1);
  localparam logic [sbcs_pkg::CNT_W-1:0] DPL_LOAD  = sbcs_pkg::CNT_W'(sbcs_pkg::DATA_IN_TO_PRECHARGE_TIME_CYC - 1);
  localparam logic [sbcs_pkg::CNT_W-1:0] TURN_LOAD = sbcs_pkg::CNT_W'(sbcs_pkg::BUS_TURN_CYC);
  localparam logic [sbcs_pkg::CNT_W-1:0] CNT_ZERO  = '0;

  logic [sbcs_pkg::NUM_BANKS-1:0]      ok;
  logic [sbcs_pkg::NUM_BANKS-1:0]      idle;
  logic [sbcs_pkg::NUM_BANKS-1:0]      wr_busy;
  logic                                take;
  logic                                ap;
  logic [sbcs_pkg::CNT_W-1:0]          turn_reg;
  logic [sbcs_pkg::CNT_W-1:0]          turn_next;
  logic [3:0]                          pin_reg;
  logic [3:0]                          pin_next;
  logic [sbcs_pkg::ADDR_W-1:0]         addr_reg;
  logic [sbcs_pkg::ADDR_W-1:0]         addr_next;

  assign ap = req_addr[sbcs_pkg::AP_BIT];

  for (genvar b = 0; b < sbcs_pkg::NUM_BANKS; b++)
  begin : g_bank
    sbcs_pkg::sbcs_bank_e          st_reg;
    sbcs_pkg::sbcs_bank_e          st_next;
    logic [sbcs_pkg::CNT_W-1:0]    cnt_reg;
    logic [sbcs_pkg::CNT_W-1:0]    cnt_next;
    logic                          hit;
    logic                          done;
    sbcs_pkg::sbcs_cmd_e           go;

    always_comb
    begin
      hit      = sbcs_pkg::bank_hit(req_op, req_addr, b);
      ok[b]    = !hit || sbcs_pkg::cmd_legal(st_reg, req_op);
      go       = (take && hit) ? req_op : sbcs_pkg::no_operation_cmd;
      done     = (cnt_reg == CNT_ZERO);
      st_next  = st_reg;
      cnt_next = done ? cnt_reg : cnt_reg - 1'b1;
      if (go == sbcs_pkg::row_activate_cmd)
      begin
        st_next  = sbcs_pkg::st_activating;
        cnt_next = RCD_LOAD;
      end
      else if (go == sbcs_pkg::read_cmd || go == sbcs_pkg::write_cmd)
      begin
        st_next  = (go == sbcs_pkg::read_cmd) ? (ap ? sbcs_pkg::st_read_ap : sbcs_pkg::st_read)
                                              : (ap ? sbcs_pkg::st_write_ap : sbcs_pkg::st_write);
        cnt_next = BL_LOAD;
      end
      else if (go == sbcs_pkg::precharge_cmd && st_reg != sbcs_pkg::st_idle && st_reg != sbcs_pkg::st_precharging)
      begin
        st_next  = sbcs_pkg::st_precharging;
        cnt_next = RP_LOAD;
      end
      else if (go == sbcs_pkg::burst_stop_cmd && (st_reg == sbcs_pkg::st_read || st_reg == sbcs_pkg::st_write))
      begin
        st_next = sbcs_pkg::st_row_active;
      end
      else if (done)
      begin
        unique case (st_reg)
          sbcs_pkg::st_activating,
          sbcs_pkg::st_read,
          sbcs_pkg::st_write_rec:    st_next = sbcs_pkg::st_row_active;
          sbcs_pkg::st_write,
          sbcs_pkg::st_write_ap:
          begin
            st_next  = (st_reg == sbcs_pkg::st_write) ? sbcs_pkg::st_write_rec : sbcs_pkg::st_write_rec_ap;
            cnt_next = DPL_LOAD;
          end
          sbcs_pkg::st_read_ap,
          sbcs_pkg::st_write_rec_ap:
          begin
            st_next  = sbcs_pkg::st_precharging;
            cnt_next = RP_LOAD;
          end
          sbcs_pkg::st_precharging:  st_next = sbcs_pkg::st_idle;
          default:                   st_next = st_reg;
        endcase
      end
    end

    always_ff @(posedge clk)
    begin
      if (!rst_n)
      begin
        st_reg  <= sbcs_pkg::st_idle;
        cnt_reg <= CNT_ZERO;
      end
      else
      begin
        st_reg  <= st_next;
        cnt_reg <= cnt_next;
      end
    end

    assign idle[b]    = (st_reg == sbcs_pkg::st_idle);
    assign wr_busy[b] = (st_reg == sbcs_pkg::st_write);
  end

  always_comb
  begin
    req_ready = &ok;
    // Refresh and mode-set only go out with every bank idle.
    if (req_op == sbcs_pkg::refresh_cmd || req_op == sbcs_pkg::mode_register_set_cmd)
    begin
      req_ready = &idle;
    end
    // A read straight after a write command without auto-precharge (a bank in st_write) waits for the internal buses to turn.
    if (req_op == sbcs_pkg::read_cmd && turn_reg != CNT_ZERO && (|wr_busy))
    begin
      req_ready = 1'b0;
    end
    take      = req_valid && req_ready;
    turn_next = (turn_reg != CNT_ZERO) ? turn_reg - 1'b1 : turn_reg;
    pin_next  = {1'b0, 3'h7};
    addr_next = addr_reg;
    if (take && req_op == sbcs_pkg::write_cmd)
    begin
      turn_next = TURN_LOAD;
    end
    if (take)
    begin
      pin_next  = (req_op == sbcs_pkg::deselect_cmd) ? 4'hF : 4'(req_op);
      addr_next = req_addr;
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      turn_reg <= CNT_ZERO;
      pin_reg  <= 4'hF;
      addr_reg <= '0;
    end
    else
    begin
      turn_reg <= turn_next;
      pin_reg  <= pin_next;
      addr_reg <= addr_next;
    end
  end

  assign pins.cs_n  = pin_reg[3];
  assign pins.ras_n = pin_reg[2];
  assign pins.cas_n = pin_reg[1];
  assign pins.we_n  = pin_reg[0];
  assign pins.addr  = addr_reg;

endmodule : sbcs_controller
`default_nettype wire

// file: tb/sbcs_monitor.sv
// Checker on the command pins between the controller and the device.
// Assumes one clock and a synchronous active-low reset.
`timescale 1ns/10ps
`default_nettype none
module sbcs_monitor (
  input wire logic                        clk,
  input wire logic                        rst_n,
  input wire logic                        cs_n,
  input wire logic                        ras_n,
  input wire logic                        cas_n,
  input wire logic                        we_n,
  input wire logic [sbcs_pkg::ADDR_W-1:0] addr
);
  logic [3:0] cmd;
  logic       bk;
  logic       ap;
  assign cmd = {cs_n, ras_n, cas_n, we_n};
  assign bk  = addr[sbcs_pkg::BANK_BIT];
  assign ap  = addr[sbcs_pkg::AP_BIT];
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  property p_act_col;
    cmd == 4'h3 |=> !(cmd inside {4'h4, 4'h5} && bk == $past(bk));
  endproperty
  a_act_col: assert property (p_act_col) else $error("column command too soon after activate");
  property p_act_pre;
    cmd == 4'h3 |=> !(cmd == 4'h2 && (ap || bk == $past(bk)));
  endproperty
  a_act_pre: assert property (p_act_pre) else $error("precharge too soon after activate");
  property p_act_mode;
    cmd == 4'h3 |=> !(cmd inside {4'h0, 4'h1}) [*2];
  endproperty
  a_act_mode: assert property (p_act_mode) else $error("refresh or mode set with a bank open");
  property p_wr_turn;
    cmd == 4'h4 |=> cmd != 4'h5;
  endproperty
  a_wr_turn: assert property (p_wr_turn) else $error("read without bus turnaround");
  property p_wrap_bst;
    cmd == 4'h4 && ap |=> cmd != 4'h6 [*3];
  endproperty
  a_wrap_bst: assert property (p_wrap_bst) else $error("burst stop in auto-precharge write");
  property p_rdap_bst;
    cmd == 4'h5 && ap |=> cmd != 4'h6 [*3];
  endproperty
  a_rdap_bst: assert property (p_rdap_bst) else $error("burst stop in auto-precharge read");
  property p_all_bank_precharge_cmd_col;
    cmd == 4'h2 && ap |=> !(cmd inside {4'h4, 4'h5}) [*2];
  endproperty
  a_all_bank_precharge_cmd_col: assert property (p_all_bank_precharge_cmd_col) else $error("column command while precharging");
  property p_reset_pins;
    $rose(rst_n) |-> cs_n;
  endproperty
  a_reset_pins: assert property (p_reset_pins) else $error("pins not deselected after reset");
endmodule : sbcs_monitor
`default_nettype wire

// file: tb/sdram_bank_command_states_tb.sv
// Testbench joining controller and device through the pin interface.
// Assumes the design package and interface are compiled first.
`timescale 1ns/10ps
`default_nettype none
module sdram_bank_command_states_tb;
  logic                        clk;
  logic                        rst_n;
  logic                        req_valid;
  logic                        req_ready;
  sbcs_pkg::sbcs_cmd_e         req_op;
  logic [11:0]                 req_addr;
  sbcs_pkg::sbcs_bank_e        bank_state [sbcs_pkg::NUM_BANKS];
  logic                        illegal_cmd;
  logic                        read_start;
  logic                        write_start;
  logic                        start_bank;
  logic [7:0]                  start_col;
  int                          fail_count;
  int                          checked;
  int                          cycles;
  int                          bad_cmds;

  sbcs_if pins_if ();
  sbcs_controller sbcs_controller_inst (.clk(clk), .rst_n(rst_n), .req_valid(req_valid),
    .req_ready(req_ready), .req_op(req_op), .req_addr(req_addr), .pins(pins_if));
  sbcs_device sbcs_device_inst (.clk(clk), .rst_n(rst_n), .pins(pins_if), .bank_state(bank_state),
    .illegal_cmd(illegal_cmd), .read_start(read_start), .write_start(write_start),
    .start_bank(start_bank), .start_col(start_col));
  sbcs_monitor sbcs_monitor_inst (.clk(clk), .rst_n(rst_n), .cs_n(pins_if.cs_n), .ras_n(pins_if.ras_n),
    .cas_n(pins_if.cas_n), .we_n(pins_if.we_n), .addr(pins_if.addr));

  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // Counts every flagged command and cuts a hang short.
  always @(posedge clk)
  begin
    cycles <= cycles + 1;
    if (rst_n && illegal_cmd !== 1'b0)
      bad_cmds <= bad_cmds + 1;
    if (cycles == 2000)
    begin
      fail_count++;
      conclude();
    end
  end

  task automatic conclude();
    $display("fail_count=%0d checked=%0d", fail_count, checked);
    if (fail_count == 0 && checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : conclude

  task automatic cmp_v(input logic [11:0] got, input logic [11:0] exp);
    checked++;
    if (got !== exp)
    begin
      fail_count++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask : cmp_v

  task automatic cmp_st(input int b, input sbcs_pkg::sbcs_bank_e exp);
    cmp_v(12'(bank_state[b]), 12'(exp));
  endtask : cmp_st

  task automatic settle();
    @(posedge clk);
    @(negedge clk);
  endtask : settle

  // Holds the request until taken, then checks the code on the pins.
  task automatic req(input sbcs_pkg::sbcs_cmd_e op, input logic [11:0] a);
    int n;
    n = 0;
    @(posedge clk);
    req_valid <= 1'b1;
    req_op    <= op;
    req_addr  <= a;
    @(negedge clk);
    while (req_ready !== 1'b1 && n < 20)
    begin
      n++;
      @(negedge clk);
    end
    cmp_v(12'(n < 20), 12'h001);
    @(posedge clk);
    req_valid <= 1'b0;
    @(negedge clk);
    if (op == sbcs_pkg::deselect_cmd)
      cmp_v(12'(pins_if.cs_n), 12'h001);
    else
      cmp_v(12'({pins_if.cs_n, pins_if.ras_n, pins_if.cas_n, pins_if.we_n}), 12'(op));
  endtask : req

  task automatic refuse(input sbcs_pkg::sbcs_cmd_e op, input logic [11:0] a);
    @(posedge clk);
    req_valid <= 1'b1;
    req_op    <= op;
    req_addr  <= a;
    @(negedge clk);
    cmp_v(12'(req_ready), 12'h000);
    @(posedge clk);
    req_valid <= 1'b0;
  endtask : refuse

  task automatic col(input sbcs_pkg::sbcs_cmd_e op, input logic [11:0] a, input sbcs_pkg::sbcs_bank_e st);
    req(op, a);
    settle();
    cmp_v(12'({read_start, write_start}), (op == sbcs_pkg::read_cmd) ? 12'h002 : 12'h001);
    cmp_v(12'({start_bank, start_col}), 12'({a[11], a[7:0]}));
    cmp_st(int'(a[11]), st);
  endtask : col

  // Counts consecutive cycles that a bank spends in one state.
  task automatic run_len(input int b, input sbcs_pkg::sbcs_bank_e st, input int exp);
    int n;
    n = 0;
    while (bank_state[b] === st && n < 20)
    begin
      n++;
      @(negedge clk);
    end
    cmp_v(12'(n), 12'(exp));
  endtask : run_len

  // Presents the second request at the edge that takes the first, so the refusal window is exercised back to back.
  task automatic back2back(input sbcs_pkg::sbcs_cmd_e op1, input logic [11:0] a1, input sbcs_pkg::sbcs_cmd_e op2,
                           input logic [11:0] a2, input int exp_wait);
    int n;
    n = 0;
    @(posedge clk);
    req_valid <= 1'b1;
    req_op    <= op1;
    req_addr  <= a1;
    @(negedge clk);
    cmp_v(12'(req_ready), 12'h001);
    @(posedge clk);
    req_op    <= op2;
    req_addr  <= a2;
    @(negedge clk);
    cmp_v(12'({pins_if.cs_n, pins_if.ras_n, pins_if.cas_n, pins_if.we_n}), 12'(op1));
    while (req_ready !== 1'b1 && n < 20)
    begin
      n++;
      @(negedge clk);
    end
    @(posedge clk);
    req_valid <= 1'b0;
    @(negedge clk);
    cmp_v(12'(n), 12'(exp_wait));
    cmp_v(12'({pins_if.cs_n, pins_if.ras_n, pins_if.cas_n, pins_if.we_n}), 12'(op2));
  endtask : back2back

  initial
  begin
    rst_n      = 1'b0;
    req_valid  = 1'b0;
    req_op     = sbcs_pkg::no_operation_cmd;
    req_addr   = 12'h000;
    fail_count = 0;
    checked    = 0;
    cycles     = 0;
    bad_cmds   = 0;
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    @(negedge clk);
    cmp_st(0, sbcs_pkg::st_idle);
    cmp_st(1, sbcs_pkg::st_idle);
    req(sbcs_pkg::row_activate_cmd, 12'h000);
    settle();
    run_len(0, sbcs_pkg::st_activating, sbcs_pkg::ACTIVATE_TO_COLUMN_DELAY_CYC);
    refuse(sbcs_pkg::row_activate_cmd, 12'h000);
    refuse(sbcs_pkg::refresh_cmd, 12'h000);
    col(sbcs_pkg::write_cmd, 12'h001, sbcs_pkg::st_write);
    col(sbcs_pkg::write_cmd, 12'h002, sbcs_pkg::st_write);
    col(sbcs_pkg::read_cmd, 12'h004, sbcs_pkg::st_read);
    col(sbcs_pkg::write_cmd, 12'h008, sbcs_pkg::st_write);
    req(sbcs_pkg::precharge_cmd, 12'h000);
    settle();
    run_len(0, sbcs_pkg::st_precharging, sbcs_pkg::TRP_CYC);
    cmp_st(0, sbcs_pkg::st_idle);
    req(sbcs_pkg::row_activate_cmd, 12'h800);
    settle();
    run_len(1, sbcs_pkg::st_activating, sbcs_pkg::ACTIVATE_TO_COLUMN_DELAY_CYC);
    col(sbcs_pkg::write_cmd, 12'hC0A, sbcs_pkg::st_write_ap);
    run_len(1, sbcs_pkg::st_write_ap, sbcs_pkg::BURST_LEN);
    run_len(1, sbcs_pkg::st_write_rec_ap, sbcs_pkg::DATA_IN_TO_PRECHARGE_TIME_CYC);
    run_len(1, sbcs_pkg::st_precharging, sbcs_pkg::TRP_CYC);
    cmp_st(1, sbcs_pkg::st_idle);
    req(sbcs_pkg::row_activate_cmd, 12'h000);
    req(sbcs_pkg::row_activate_cmd, 12'h800);
    repeat (3) settle();
    cmp_st(0, sbcs_pkg::st_row_active);
    cmp_st(1, sbcs_pkg::st_row_active);
    col(sbcs_pkg::read_cmd, 12'h403, sbcs_pkg::st_read_ap);
    refuse(sbcs_pkg::burst_stop_cmd, 12'h000);
    refuse(sbcs_pkg::write_cmd, 12'h000);
    col(sbcs_pkg::write_cmd, 12'h805, sbcs_pkg::st_write);
    req(sbcs_pkg::burst_stop_cmd, 12'h000);
    settle();
    cmp_st(1, sbcs_pkg::st_row_active);
    cmp_st(0, sbcs_pkg::st_idle);
    back2back(sbcs_pkg::row_activate_cmd, 12'h000, sbcs_pkg::write_cmd, 12'h001, sbcs_pkg::ACTIVATE_TO_COLUMN_DELAY_CYC);
    settle();
    run_len(0, sbcs_pkg::st_write, sbcs_pkg::BURST_LEN);
    run_len(0, sbcs_pkg::st_write_rec, sbcs_pkg::DATA_IN_TO_PRECHARGE_TIME_CYC);
    cmp_st(0, sbcs_pkg::st_row_active);
    back2back(sbcs_pkg::write_cmd, 12'h002, sbcs_pkg::read_cmd, 12'h004, sbcs_pkg::BUS_TURN_CYC);
    req(sbcs_pkg::precharge_cmd, 12'h400);
    settle();
    run_len(1, sbcs_pkg::st_precharging, sbcs_pkg::TRP_CYC);
    cmp_st(1, sbcs_pkg::st_idle);
    cmp_st(0, sbcs_pkg::st_idle);
    req(sbcs_pkg::refresh_cmd, 12'h000);
    req(sbcs_pkg::mode_register_set_cmd, 12'h000);
    req(sbcs_pkg::no_operation_cmd, 12'h000);
    req(sbcs_pkg::deselect_cmd, 12'h000);
    repeat (2) settle();
    cmp_v(12'(bad_cmds), 12'h000);
    conclude();
  end
endmodule : sdram_bank_command_states_tb
`default_nettype wire
